// ===== hdl/nxb_bank_mem.sv
// Eight control banks of sixteen nibbles with two registered read ports.
`timescale 1ns/1ns
`default_nettype none
module nxb_bank_mem (
   input wire logic clk,
   input wire logic sys_rst,
   input wire nxb_pkg::nxb_mem_wr_t wr,
   input wire logic [2:0] rd_a_addr,
   input wire logic [2:0] rd_b_addr,
   output var logic [63:0] rd_a_data,
   output var logic [63:0] rd_b_data
);
   import nxb_pkg::*;

   typedef struct packed {
      logic [7:0][63:0] bank;
      logic [63:0] rd_a;
      logic [63:0] rd_b;
   } nxb_mem_state_t;

   nxb_mem_state_t s;
   nxb_mem_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // Only masked groups of the addressed bank change on a write.
   always_comb begin
      next_s = s;
      if (wr.en) begin
         for (int g = 0; g < 16; g++) begin
            if (wr.mask[g]) begin
               next_s.bank[wr.addr][4*g +: 4] = wr.data[4*g +: 4];
            end
         end
      end
      next_s.rd_a = s.bank[rd_a_addr];
      next_s.rd_b = s.bank[rd_b_addr];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_a_data = s.rd_a;
   assign rd_b_data = s.rd_b;

   ////////////////////////////////////////////////////////////////////////////
   // Checks of the storage.
   function automatic logic [63:0] nxb_spread16(input logic [15:0] m);
      logic [63:0] r;
      r = 64'h0;
      for (int g = 0; g < 16; g++) begin
         r[4*g +: 4] = {4{m[g]}};
      end
      return r;
   endfunction : nxb_spread16

   a_mem_hold_idle: assert property (
      @(posedge clk) disable iff (sys_rst)
      !wr.en |=> $stable(s.bank))
      else $error("bank contents changed without a write");

   a_mem_masked_store: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr.en |=> ((s.bank[$past(wr.addr)] ^ $past(wr.data))
                 & nxb_spread16($past(wr.mask))) == 64'h0)
      else $error("masked groups not stored");

endmodule : nxb_bank_mem
`default_nettype wire

// ===== hdl/nxb_crossbar.sv
// Bank programming, selection, readback and routing of the nibble crossbar.
// What this block does
// - Active select 1xx0 routes through fixed upper/lower nibble exchange.
// - Control code 0-7 picks lower nibbles, 8-15 picks upper nibbles.
// - A full bank load over the port takes four load strobes.
// - Word address a stores port nibbles into groups a, a+4, a+8, a+12.
// - Active select with top bit low routes from bank of low bits.
// - Both real-time selects low take sources from the input registers.
// - Data-side load maps each half onto the other half in one strobe.
// - Data-side loads use live inputs or earlier captured half words.
// - Four port reads return a whole bank, 16 bits each.
// - Read bank select and word address choose the word driven out.
// - Readback word layout equals the load layout.
// - Every output group keeps its own independent control word.
// - With write enable high, load strobes leave all banks unchanged.
// - Load source high takes bank data from data inputs, low from port.
// - A half's real-time select high routes its live inputs.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nxb_crossbar (
   input wire logic clk,
   input wire logic sys_rst,
   input wire nxb_pkg::nxb_avs_req_t avs_req,
   output var nxb_pkg::nxb_avs_rsp_t avs_rsp,
   input wire logic [63:0] data_in,
   output var logic [63:0] data_out,
   output var logic [15:0] data_out_oe,
   input wire logic [15:0] control_word_port_in,
   output var logic [15:0] control_word_port_out,
   output var logic control_word_port_oe
);
   import nxb_pkg::*;

   nxb_state_t s;
   nxb_state_t next_s;
   nxb_mem_wr_t mem_wr;
   logic [63:0] rd_a;
   logic [63:0] rd_b;
   logic [63:0] src;
   logic bus_req;
   logic bus_acc;
   logic bus_wr;
   logic stb_hit;
   logic load_stb;
   logic [31:0] ctrl_merged;
   logic [31:0] oed_merged;
   logic [31:0] stb_word;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode: a request is answered one cycle after it is seen.
   assign bus_req = avs_req.read | avs_req.write;
   assign bus_acc = bus_req & ~s.waitrequest;
   assign bus_wr = bus_acc & avs_req.write;
   assign stb_hit = bus_wr & (avs_req.address == NXB_OFS_STROBE);
   assign stb_word = nxb_be_merge(NXB_WORD_RST, avs_req.writedata,
                                  avs_req.byteenable);
   assign load_stb = stb_hit & stb_word[NXB_STB_LOAD];
   assign ctrl_merged = nxb_be_merge({15'h0, s.ctrl}, avs_req.writedata,
                                     avs_req.byteenable);
   assign oed_merged = nxb_be_merge({16'h0, s.oed_n}, avs_req.writedata,
                                    avs_req.byteenable);

   always_comb begin
      case (avs_req.address)
         NXB_OFS_CTRL: rd_mux = {15'h0, s.ctrl};
         NXB_OFS_OED: rd_mux = {16'h0, s.oed_n};
         NXB_OFS_RDBK: rd_mux = {16'h0, s.cport_out};
         NXB_OFS_PORT: rd_mux = {16'h0, s.cport_sync};
         default: rd_mux = NXB_WORD_RST;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source nibbles: live inputs or input registers per half.
   assign src[63:32] = s.ctrl.upper_half_realtime_sel ?
                       s.din_sync[63:32] : s.upper_reg;
   assign src[31:0] = s.ctrl.lower_half_realtime_sel ?
                      s.din_sync[31:0] : s.lower_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bank write request.
   always_comb begin
      mem_wr.en = load_stb & ~s.ctrl.we_n;
      mem_wr.addr = s.ctrl.write_bank_sel;
      if (s.ctrl.control_load_source_sel) begin
         mem_wr.mask = NXB_GRP_ALL;
         mem_wr.data = nxb_swap(src);
      end else begin
         mem_wr.mask = NXB_GRP_MASK0 << s.ctrl.word_group_addr;
         mem_wr.data = nxb_spread(s.cport_sync,
                                  s.ctrl.word_group_addr);
      end
   end

   nxb_bank_mem u_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(mem_wr),
      .rd_a_addr(s.ctrl.active_bank_sel[2:0]),
      .rd_b_addr(s.ctrl.read_bank_sel),
      .rd_a_data(rd_a),
      .rd_b_data(rd_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      next_s = s;
      next_s.din_meta = data_in;
      next_s.din_sync = s.din_meta;
      next_s.cport_meta = control_word_port_in;
      next_s.cport_sync = s.cport_meta;
      next_s.waitrequest = ~(bus_req & s.waitrequest);
      if (bus_req & s.waitrequest) begin
         next_s.readdata = rd_mux;
      end
      if (bus_wr && avs_req.address == NXB_OFS_CTRL) begin
         next_s.ctrl = nxb_ctrl_t'(ctrl_merged[16:0]);
      end
      if (bus_wr && avs_req.address == NXB_OFS_OED) begin
         next_s.oed_n = oed_merged[15:0];
      end
      if (stb_hit & stb_word[NXB_STB_UPPER]) begin
         next_s.upper_reg = s.din_sync[63:32];
      end
      if (stb_hit & stb_word[NXB_STB_LOWER]) begin
         next_s.lower_reg = s.din_sync[31:0];
      end
      if (nxb_is_xchg(s.ctrl.active_bank_sel)) begin
         next_s.data_out = nxb_swap(src);
      end else begin
         next_s.data_out = nxb_route(rd_a, src);
      end
      next_s.data_out_oe = ~s.oed_n;
      next_s.cport_out = nxb_pick(rd_b,
                                  s.ctrl.word_group_addr);
      next_s.cport_oe = ~s.ctrl.oec_n;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= NXB_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   assign avs_rsp.readdata = s.readdata;
   assign avs_rsp.waitrequest = s.waitrequest;
   assign data_out = s.data_out;
   assign data_out_oe = s.data_out_oe;
   assign control_word_port_out = s.cport_out;
   assign control_word_port_oe = s.cport_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_bus_answer_next: assert property (
      bus_req && s.waitrequest |=> !s.waitrequest ##1 s.waitrequest)
      else $error("bus answer not given one cycle after request");

   a_we_inhibit_load: assert property (
      load_stb && s.ctrl.we_n |-> !mem_wr.en)
      else $error("bank written while write enable high");

   a_port_group_map: assert property (
      mem_wr.en && !s.ctrl.control_load_source_sel |->
      mem_wr.mask == (NXB_GRP_MASK0 << s.ctrl.word_group_addr) &&
      nxb_pick(mem_wr.data, s.ctrl.word_group_addr) == s.cport_sync)
      else $error("port word placed in wrong groups");

   a_data_load_swap: assert property (
      mem_wr.en && s.ctrl.control_load_source_sel |->
      mem_wr.mask == NXB_GRP_ALL && mem_wr.data == {src[31:0], src[63:32]})
      else $error("data-side load not swapped or not whole");

   a_xchg_route_out: assert property (
      nxb_is_xchg(s.ctrl.active_bank_sel) |=>
      data_out == {$past(src[31:0]), $past(src[63:32])})
      else $error("exchange routing wrong");

   a_bank_route_out: assert property (
      !nxb_is_xchg(s.ctrl.active_bank_sel) |=>
      data_out == nxb_route($past(rd_a), $past(src)))
      else $error("bank routing wrong");

   a_reg_source_sel: assert property (
      !s.ctrl.upper_half_realtime_sel && !s.ctrl.lower_half_realtime_sel |->
      src == {s.upper_reg, s.lower_reg})
      else $error("registered sources not used");

   a_live_source_sel: assert property (
      s.ctrl.upper_half_realtime_sel |-> src[63:32] == s.din_sync[63:32])
      else $error("live upper inputs not used");

   a_port_release_hi: assert property (
      s.ctrl.oec_n [*2] |-> !control_word_port_oe)
      else $error("control port driven while disabled");

   a_readback_word: assert property (
      s.ctrl.read_bank_sel == $past(s.ctrl.read_bank_sel) [*2] |->
      ##1 control_word_port_out ==
      nxb_pick($past(rd_b), $past(s.ctrl.word_group_addr)))
      else $error("readback word wrong");

   a_oed_nibble_drive: assert property (
      s.oed_n == 16'h0 [*2] |-> data_out_oe == 16'hffff)
      else $error("enabled nibbles not driven");

   c_port_load: cover property (mem_wr.en && !s.ctrl.control_load_source_sel);
   c_data_load: cover property (mem_wr.en && s.ctrl.control_load_source_sel);
   c_xchg_mode: cover property (nxb_is_xchg(s.ctrl.active_bank_sel));
   c_readback: cover property (control_word_port_oe && bus_acc);

endmodule : nxb_crossbar
`default_nettype wire

// ===== hdl/nxb_pkg.sv
// Shared constants, carrier types and helper functions of the nibble crossbar.
package nxb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] NXB_OFS_CTRL = 5'h00;
   localparam logic [4:0] NXB_OFS_STROBE = 5'h04;
   localparam logic [4:0] NXB_OFS_OED = 5'h08;
   localparam logic [4:0] NXB_OFS_RDBK = 5'h0c;
   localparam logic [4:0] NXB_OFS_PORT = 5'h10;

   // Bit positions in the strobe register.
   localparam int NXB_STB_LOAD = 0;
   localparam int NXB_STB_UPPER = 1;
   localparam int NXB_STB_LOWER = 2;

   // Values after reset.
   localparam logic [16:0] NXB_CTRL_RST = 17'h11000;
   localparam logic [15:0] NXB_OED_RST = 16'hffff;
   localparam logic [31:0] NXB_WORD_RST = 32'h0;
   localparam logic [63:0] NXB_QUAD_RST = 64'h0;

   // Group masks for port loads and whole-bank loads.
   localparam logic [15:0] NXB_GRP_MASK0 = 16'h1111;
   localparam logic [15:0] NXB_GRP_ALL = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Control register layout, most significant field first.
   typedef struct packed {
      logic oec_n;
      logic [2:0] read_bank_sel;
      logic we_n;
      logic lower_half_realtime_sel;
      logic upper_half_realtime_sel;
      logic [3:0] active_bank_sel;
      logic [1:0] word_group_addr;
      logic [2:0] write_bank_sel;
      logic control_load_source_sel;
   } nxb_ctrl_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } nxb_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } nxb_avs_rsp_t;

   typedef struct packed {
      logic en;
      logic [2:0] addr;
      logic [15:0] mask;
      logic [63:0] data;
   } nxb_mem_wr_t;

   ////////////////////////////////////////////////////////////////////////////
   // Swaps every upper-half nibble with its lower-half partner.
   function automatic logic [63:0] nxb_swap(input logic [63:0] x);
      return {x[31:0], x[63:32]};
   endfunction : nxb_swap

   // Exchange mode is most significant select bit high, least one low.
   function automatic logic nxb_is_xchg(input logic [3:0] sel);
      return sel[3] & ~sel[0];
   endfunction : nxb_is_xchg

   // Each output group takes the source nibble numbered by its control word.
   function automatic logic [63:0] nxb_route(input logic [63:0] sel,
                                             input logic [63:0] src);
      logic [63:0] r;
      logic [3:0] c;
      r = NXB_QUAD_RST;
      for (int g = 0; g < 16; g++) begin
         c = sel[4*g +: 4];
         r[4*g +: 4] = src[{c, 2'b00} +: 4];
      end
      return r;
   endfunction : nxb_route

   // Gathers groups a, a+4, a+8 and a+12 into one 16-bit port word.
   function automatic logic [15:0] nxb_pick(input logic [63:0] bank,
                                            input logic [1:0] a);
      logic [15:0] w;
      w = 16'h0;
      for (int k = 0; k < 4; k++) begin
         w[4*k +: 4] = bank[(4*k + int'(a))*4 +: 4];
      end
      return w;
   endfunction : nxb_pick

   // Places a port word into groups a, a+4, a+8 and a+12.
   function automatic logic [63:0] nxb_spread(input logic [15:0] w,
                                              input logic [1:0] a);
      logic [63:0] r;
      r = NXB_QUAD_RST;
      for (int k = 0; k < 4; k++) begin
         r[(4*k + int'(a))*4 +: 4] = w[4*k +: 4];
      end
      return r;
   endfunction : nxb_spread

   // Byte-enable merge of a bus write into a register image.
   function automatic logic [31:0] nxb_be_merge(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : nxb_be_merge

   ////////////////////////////////////////////////////////////////////////////
   // Whole state of the top module.
   typedef struct packed {
      nxb_ctrl_t ctrl;
      logic [15:0] oed_n;
      logic [31:0] upper_reg;
      logic [31:0] lower_reg;
      logic [63:0] din_meta;
      logic [63:0] din_sync;
      logic [15:0] cport_meta;
      logic [15:0] cport_sync;
      logic waitrequest;
      logic [31:0] readdata;
      logic [63:0] data_out;
      logic [15:0] data_out_oe;
      logic [15:0] cport_out;
      logic cport_oe;
   } nxb_state_t;

   localparam nxb_state_t NXB_STATE_RST = '{
      ctrl: nxb_ctrl_t'(NXB_CTRL_RST),
      oed_n: NXB_OED_RST,
      upper_reg: NXB_WORD_RST,
      lower_reg: NXB_WORD_RST,
      din_meta: NXB_QUAD_RST,
      din_sync: NXB_QUAD_RST,
      cport_meta: 16'h0,
      cport_sync: 16'h0,
      waitrequest: 1'b1,
      readdata: NXB_WORD_RST,
      data_out: NXB_QUAD_RST,
      data_out_oe: 16'h0,
      cport_out: 16'h0,
      cport_oe: 1'b0
   };

endpackage : nxb_pkg

// ===== verification/nibble_crossbar_bank_programming_bench.sv
// Self-checking bench of the nibble crossbar bank programming block.
`timescale 1ns/1ns
`default_nettype none
module nibble_crossbar_bank_programming_bench;
   import nxb_pkg::*;
   logic clk, sys_rst, port_oe;
   nxb_avs_req_t avs_req;
   nxb_avs_rsp_t avs_rsp, rsp_q;
   logic [63:0] data_in, data_out, next_data, x, y, regs;
   logic [15:0] data_out_oe, port_in, port_out, next_word, r16;
   logic [31:0] rdat;
   nxb_ctrl_t ctl;
   int n_mismatch, checks_done;
   integer seed;

   nxb_crossbar u_nxb_crossbar (.clk(clk), .sys_rst(sys_rst),
      .avs_req(avs_req), .avs_rsp(avs_rsp), .data_in(data_in),
      .data_out(data_out), .data_out_oe(data_out_oe),
      .control_word_port_in(port_in), .control_word_port_out(port_out),
      .control_word_port_oe(port_oe));
   nxb_far_end u_nxb_far_end (.clk(clk), .next_data(next_data),
      .next_word(next_word), .port_out(port_out), .port_oe(port_oe),
      .data_in(data_in), .port_in(port_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge clk) rsp_q <= avs_rsp;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] word_of(input logic [63:0] b, input int a);
      logic [15:0] w;
      for (int k = 0; k < 4; k++) begin
         w[4*k +: 4] = b[16*k + 4*a +: 4];
      end
      return w;
   endfunction : word_of

   function automatic logic [63:0] exp_route(input logic [63:0] b,
                                             input logic [63:0] s);
      logic [63:0] r;
      for (int g = 0; g < 16; g++) begin
         r[4*g +: 4] = s[4*int'(b[4*g +: 4]) +: 4];
      end
      return r;
   endfunction : exp_route

   function automatic logic [63:0] xchg_img();
      logic [63:0] r;
      for (int g = 0; g < 16; g++) begin
         r[4*g +: 4] = 4'(g ^ 8);
      end
      return r;
   endfunction : xchg_img

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic bus(input logic rd, input logic [4:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      avs_req.read <= rd;
      avs_req.write <= ~rd;
      avs_req.address <= a;
      avs_req.writedata <= wd;
      avs_req.byteenable <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_q.waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         $display("MISMATCH %0t bus access never answered", $time);
      end
      rdat = rsp_q.readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
   endtask : bus

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic wr_ctrl();
      bus(1'b0, NXB_OFS_CTRL, {15'h0, ctl});
   endtask : wr_ctrl

   task automatic strobe(input int b);
      bus(1'b0, NXB_OFS_STROBE, 32'h1 << b);
   endtask : strobe

   task automatic load_port(input logic [2:0] bank, input logic [63:0] img);
      ctl.control_load_source_sel = 1'b0;
      ctl.write_bank_sel = bank;
      ctl.we_n = 1'b0;
      for (int a = 0; a < 4; a++) begin
         next_word <= word_of(img, a);
         settle(2);
         ctl.word_group_addr = 2'(a);
         wr_ctrl();
         strobe(NXB_STB_LOAD);
      end
      ctl.we_n = 1'b1;
   endtask : load_port

   task automatic read_bank(input logic [2:0] bank, input logic [63:0] exp);
      logic [15:0] w;
      ctl.we_n = 1'b1;
      ctl.oec_n = 1'b0;
      ctl.read_bank_sel = bank;
      for (int a = 0; a < 4; a++) begin
         ctl.word_group_addr = 2'(a);
         wr_ctrl();
         settle(3);
         w = word_of(exp, a);
         chk({48'h0, port_out}, {48'h0, w}, "readback");
         chk({63'h0, port_oe}, 64'h1, "port drive");
         bus(1'b1, NXB_OFS_RDBK, 32'h0);
         chk({32'h0, rdat}, {48'h0, w}, "readback reg");
         bus(1'b1, NXB_OFS_PORT, 32'h0);
         chk({32'h0, rdat}, {48'h0, w}, "port pins");
      end
      ctl.oec_n = 1'b1;
      wr_ctrl();
   endtask : read_bank

   task automatic route(input logic [3:0] act, input logic up,
                        input logic lo, input logic [63:0] live,
                        input logic [63:0] exp);
      ctl.active_bank_sel = act;
      ctl.upper_half_realtime_sel = up;
      ctl.lower_half_realtime_sel = lo;
      wr_ctrl();
      next_data <= live;
      settle(6);
      chk(data_out, exp, "routed data");
   endtask : route

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      seed = 32'h244b9fb2;
      avs_req = '0;
      next_data = 64'h0;
      next_word = 16'h0;
      ctl = nxb_ctrl_t'(NXB_CTRL_RST);
      n_mismatch = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b1, NXB_OFS_CTRL, 32'h0);
      chk({32'h0, rdat}, 64'h11000, "ctrl after reset");
      bus(1'b1, 5'h14, 32'h0);
      chk({32'h0, rdat}, 64'h0, "unmapped read");
      chk({63'h0, port_oe}, 64'h0, "port idle");
      // Exchange pattern over the port, then a load with writes inhibited.
      load_port(3'h7, xchg_img());
      next_word <= 16'h5a5a;
      settle(2);
      wr_ctrl();
      strobe(NXB_STB_LOAD);
      read_bank(3'h7, xchg_img());
      // Capture both input registers with writes inhibited.
      x = {$random(seed), $random(seed)};
      y = {$random(seed), $random(seed)};
      next_data <= x;
      settle(4);
      strobe(NXB_STB_UPPER);
      next_data <= y;
      settle(4);
      strobe(NXB_STB_LOWER);
      regs = {x[63:32], y[31:0]};
      r16 = 16'($random(seed));
      bus(1'b0, NXB_OFS_OED, {16'h0, r16});
      settle(2);
      chk({48'h0, data_out_oe}, {48'h0, ~r16}, "nibble enables");
      bus(1'b0, NXB_OFS_OED, 32'h0);
      x = {$random(seed), $random(seed)};
      y = {regs[31:0], regs[63:32]};
      route(4'h7, 1'b0, 1'b0, x, y);
      route(4'h8, 1'b1, 1'b1, x, {x[31:0], x[63:32]});
      route(4'he, 1'b1, 1'b0, x, {regs[31:0], x[63:32]});
      // Whole bank 1 from live inputs in one strobe.
      bus(1'b0, NXB_OFS_OED, 32'hffff);
      x = {$random(seed), $random(seed)};
      next_data <= x;
      ctl.control_load_source_sel = 1'b1;
      ctl.write_bank_sel = 3'h1;
      ctl.we_n = 1'b0;
      ctl.upper_half_realtime_sel = 1'b1;
      ctl.lower_half_realtime_sel = 1'b1;
      wr_ctrl();
      settle(4);
      strobe(NXB_STB_LOAD);
      read_bank(3'h1, {x[31:0], x[63:32]});
      bus(1'b0, NXB_OFS_OED, 32'h0);
      y = {$random(seed), $random(seed)};
      x = {x[31:0], x[63:32]};
      route(4'h1, 1'b1, 1'b1, y, exp_route(x, y));
      // Bank 2 from the captured input registers.
      ctl.control_load_source_sel = 1'b1;
      ctl.write_bank_sel = 3'h2;
      ctl.we_n = 1'b0;
      ctl.upper_half_realtime_sel = 1'b0;
      ctl.lower_half_realtime_sel = 1'b0;
      wr_ctrl();
      strobe(NXB_STB_LOAD);
      read_bank(3'h2, {regs[31:0], regs[63:32]});
      // Random per-group patterns through bank 3.
      for (int i = 0; i < 3; i++) begin
         x = {$random(seed), $random(seed)};
         y = {$random(seed), $random(seed)};
         load_port(3'h3, x);
         route(4'h3, 1'b1, 1'b1, y, exp_route(x, y));
      end
      wrap_up();
   end
endmodule : nibble_crossbar_bank_programming_bench
`default_nettype wire

// ===== verification/nxb_far_end.sv
// Model of the controller pins that face the crossbar.
`timescale 1ns/1ns
`default_nettype none
module nxb_far_end (
   input wire logic clk,
   input wire logic [63:0] next_data,
   input wire logic [15:0] next_word,
   input wire logic [15:0] port_out,
   input wire logic port_oe,
   output var logic [63:0] data_in,
   output var logic [15:0] port_in
);
   logic [15:0] word;
   // Pins change just after a clock edge and then hold.
   always @(posedge clk) begin
      data_in <= next_data;
      word <= next_word;
   end
   // The controller lets go of the port while the device drives it.
   assign port_in = port_oe ? port_out : word;
endmodule : nxb_far_end
`default_nettype wire
